/* src/sdr_port.sv */
// Byte-wide serial port: status flags, select management and data buffer
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defines.svh"

// What this block does
// - Set done flag at byte end, interrupt
// - Clear done after status read, data access
// - Ignore data writes while done, unread status
// - Write during shifting sets collision flag
// - Overrun when byte arrives while done set
// - Status read clears overrun flag
// - Select low in master sets fault flag
// - Clear fault: status read then control write
// - Output disable stops driving data output
// - Soft source ignores pin, uses soft level
// - Soft level zero means selected
// - Master data write starts one byte
// - Copy shift register to buffer at end
// - Data read returns buffer, not shifter
// - Data write loads shifter directly
// - Reset clears whole status register
// - Fault clears port enable and master
// - Master drives clock, swaps data pins
// - One interrupt gated by enable bit
module sdr_port
  import sdr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire sdr_pkg::sdr_addr_t addr_i,
  input wire sdr_pkg::sdr_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i,
  output logic ss_pin_free_o
);
  import sdr_pkg::*;

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] sck_s_r, mosi_s_r, miso_s_r, ss_s_r;
  logic sck_d_r;

  // Release reset through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Two-flop synchronisers for pins
  // Select idles high so no fault is seen while reset ends
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_s_r <= 2'b00;
      mosi_s_r <= 2'b00;
      miso_s_r <= 2'b00;
      ss_s_r <= 2'b11;
      sck_d_r <= 1'b0;
    end
    else
    begin
      sck_s_r <= {sck_s_r[0], sck_i};
      mosi_s_r <= {mosi_s_r[0], mosi_i};
      miso_s_r <= {miso_s_r[0], miso_i};
      ss_s_r <= {ss_s_r[0], ss_n_i};
      sck_d_r <= sck_s_r[1];
    end
  end

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [7:0] ctrl_r, csr_r;
  sdr_byte_t shift_r, rxbuf_r;
  logic csr_seen_r, master_fault_flag_seen_r;
  sdr_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] div_r;
  logic sck_int_r;
  // Bit taken on the leading edge, waits for the trailing edge
  logic rx_bit_r;
  logic wr_data, rd_data, wr_ctrl, rd_csr, wr_csr;
  logic master, sel_n, data_write_ok, byte_end, fault;
  logic tick, lead_edge, trail_edge, sample_in;

  assign wr_data = wr_i && (addr_i == `SDR_ADDR_DATA);
  assign rd_data = rd_i && (addr_i == `SDR_ADDR_DATA);
  assign wr_ctrl = wr_i && (addr_i == `SDR_ADDR_CTRL);
  assign wr_csr = wr_i && (addr_i == `SDR_ADDR_CSR);
  assign rd_csr = rd_i && (addr_i == `SDR_ADDR_CSR);
  assign master = ctrl_r[`SDR_CTRL_MASTER];
  // Internal select from soft level or pin
  assign sel_n = csr_r[`SDR_CSR_SSM] ? csr_r[`SDR_CSR_SSI] : ss_s_r[1];
  assign fault = master && ctrl_r[`SDR_CTRL_PORT_EN] && !sel_n;
  // Writes blocked while done flag set and status unread
  assign data_write_ok = wr_data && !(csr_r[`SDR_CSR_DONE] && !csr_seen_r);
  // Serial input: far slave's answer as master, far master's data as slave
  assign sample_in = master ? miso_s_r[1] : mosi_s_r[1];

  // ----------------------------------------
  // Master clock divider and edge finder
  // ----------------------------------------
  // Divider enables a half-period tick in master mode
  // Counting only while shifting keeps each byte's first half-period full
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 7'h00;
    else if (state_r != SDR_SHIFT || tick)
      div_r <= 7'h00;
    else
      div_r <= div_r + 7'h01;
  end
  assign tick = master && (div_r == (ctrl_r[`SDR_CTRL_DIV_EN] ? 7'h01 : 7'h03));

  // Leading and trailing edges: own clock or sampled pin
  always_comb
  begin
    if (master)
    begin
      lead_edge = tick && !sck_int_r;
      trail_edge = tick && sck_int_r;
    end
    else
    begin
      lead_edge = !sel_n && (sck_s_r[1] != sck_d_r)
                  && (sck_s_r[1] != ctrl_r[`SDR_CTRL_CPOL]);
      trail_edge = !sel_n && (sck_s_r[1] != sck_d_r)
                   && (sck_s_r[1] == ctrl_r[`SDR_CTRL_CPOL]);
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  // Byte sequencer, sample on leading edge, shift on trailing
  // The shifter moves only on the trailing edge, so the data output
  // never changes beside the edge on which the far side samples it
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SDR_IDLE;
      bit_cnt_r <= 4'h0;
      sck_int_r <= 1'b0;
      shift_r <= 8'h00;
      rx_bit_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        SDR_IDLE:
        begin
          sck_int_r <= 1'b0;
          bit_cnt_r <= 4'h0;
          if (data_write_ok)
            shift_r <= wdata_i;
          if (data_write_ok && master && ctrl_r[`SDR_CTRL_PORT_EN])
            state_r <= SDR_SHIFT;
          else if (!master && ctrl_r[`SDR_CTRL_PORT_EN] && !sel_n)
            state_r <= SDR_SHIFT;
        end
        SDR_SHIFT:
        begin
          if (tick)
            sck_int_r <= !sck_int_r;
          if (lead_edge)
            rx_bit_r <= sample_in;
          if (trail_edge)
          begin
            shift_r <= {shift_r[6:0], rx_bit_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (trail_edge && bit_cnt_r == `SDR_BYTE_BITS - 4'h1)
            state_r <= SDR_DONE;
          else if (!ctrl_r[`SDR_CTRL_PORT_EN] || (!master && sel_n) || fault)
            state_r <= SDR_IDLE;
        end
        SDR_DONE:
          state_r <= SDR_IDLE;
        default:
          state_r <= SDR_IDLE;
      endcase
    end
  end
  assign byte_end = (state_r == SDR_DONE);

  // Receive buffer filled at byte end unless overrun
  // On overrun the older unread byte is kept
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rxbuf_r <= 8'h00;
    else if (byte_end && !csr_r[`SDR_CSR_DONE])
      rxbuf_r <= shift_r;
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Software writes; fault drops enable and master
  // A fault outranks a software write in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= `SDR_CTRL_RESET;
    else if (fault)
    begin
      ctrl_r[`SDR_CTRL_PORT_EN] <= 1'b0;
      ctrl_r[`SDR_CTRL_MASTER] <= 1'b0;
    end
    else if (wr_ctrl)
      ctrl_r <= wdata_i;
  end

  // ----------------------------------------
  // Status register and clear sequences
  // ----------------------------------------
  // Remember status reads for the two-step clears
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csr_seen_r <= 1'b0;
      master_fault_flag_seen_r <= 1'b0;
    end
    else
    begin
      if (rd_csr)
        csr_seen_r <= 1'b1;
      else if (rd_data || wr_data)
        csr_seen_r <= 1'b0;
      if (rd_csr && csr_r[`SDR_CSR_MASTER_FAULT_FLAG])
        master_fault_flag_seen_r <= 1'b1;
      else if (wr_ctrl)
        master_fault_flag_seen_r <= 1'b0;
    end
  end

  // Flags: set wins over clear
  // A completing byte always sets done even under a clear access
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      csr_r <= `SDR_CSR_RESET;
    else
    begin
      if (wr_csr)
        csr_r[2:0] <= wdata_i[2:0];
      if (byte_end)
        csr_r[`SDR_CSR_DONE] <= 1'b1;
      else if (csr_seen_r && (rd_data || wr_data))
        csr_r[`SDR_CSR_DONE] <= 1'b0;
      if (wr_data && state_r == SDR_SHIFT)
        csr_r[`SDR_CSR_WRITE_COLLISION_FLAG] <= 1'b1;
      else if (csr_seen_r && (rd_data || wr_data))
        csr_r[`SDR_CSR_WRITE_COLLISION_FLAG] <= 1'b0;
      if (byte_end && csr_r[`SDR_CSR_DONE])
        csr_r[`SDR_CSR_OVR] <= 1'b1;
      else if (rd_csr)
        csr_r[`SDR_CSR_OVR] <= 1'b0;
      if (fault)
        csr_r[`SDR_CSR_MASTER_FAULT_FLAG] <= 1'b1;
      else if (master_fault_flag_seen_r && wr_ctrl)
        csr_r[`SDR_CSR_MASTER_FAULT_FLAG] <= 1'b0;
      csr_r[3] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data and pin outputs
  // ----------------------------------------
  // Registered read answer, one cycle after strobe
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 8'h00;
    else if (rd_i)
      case (addr_i)
        `SDR_ADDR_DATA: rdata_o <= rxbuf_r;
        `SDR_ADDR_CTRL: rdata_o <= ctrl_r;
        `SDR_ADDR_CSR: rdata_o <= csr_r;
        default: rdata_o <= 8'h00;
      endcase
    else
      rdata_o <= 8'h00;
  end

  // Interrupt and pin drivers from flops
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_o <= 1'b0;
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      ss_pin_free_o <= 1'b0;
    end
    else
    begin
      irq_o <= ctrl_r[`SDR_CTRL_IRQ_EN] && (csr_r[`SDR_CSR_DONE]
               || csr_r[`SDR_CSR_OVR] || csr_r[`SDR_CSR_MASTER_FAULT_FLAG]);
      sck_o <= sck_int_r ^ ctrl_r[`SDR_CTRL_CPOL];
      sck_oe_o <= ctrl_r[`SDR_CTRL_PORT_EN] && master;
      mosi_o <= shift_r[7];
      miso_o <= shift_r[7];
      mosi_oe_o <= ctrl_r[`SDR_CTRL_PORT_EN] && master
                   && !csr_r[`SDR_CSR_SOD];
      miso_oe_o <= ctrl_r[`SDR_CTRL_PORT_EN] && !master && !sel_n
                   && !csr_r[`SDR_CSR_SOD];
      ss_pin_free_o <= csr_r[`SDR_CSR_SSM];
    end
  end

endmodule
`default_nettype wire

/* src/sdr_defines.svh */
// Register offsets, bit positions, reset values and timing counts of the serial port
`ifndef SDR_DEFINES_SVH
`define SDR_DEFINES_SVH
`define SDR_ADDR_DATA 8'h21
`define SDR_ADDR_CTRL 8'h22
`define SDR_ADDR_CSR 8'h23
`define SDR_CTRL_IRQ_EN 7
`define SDR_CTRL_PORT_EN 6
`define SDR_CTRL_DIV_EN 5
`define SDR_CTRL_MASTER 4
`define SDR_CTRL_CPOL 3
`define SDR_CTRL_CPHA 2
`define SDR_CSR_DONE 7
`define SDR_CSR_WRITE_COLLISION_FLAG 6
`define SDR_CSR_OVR 5
`define SDR_CSR_MASTER_FAULT_FLAG 4
`define SDR_CSR_SOD 2
`define SDR_CSR_SSM 1
`define SDR_CSR_SSI 0
`define SDR_CTRL_RESET 8'h00
`define SDR_CSR_RESET 8'h00
`define SDR_BYTE_BITS 4'h8
`define SDR_DIV_MAX 7'h7f
`endif

/* src/sdr_pkg.sv */
// Types shared by the serial data port
package sdr_pkg;
  typedef logic [7:0] sdr_byte_t;
  typedef logic [7:0] sdr_addr_t;
  typedef enum logic [1:0] {SDR_IDLE, SDR_SHIFT, SDR_DONE} sdr_state_e;
endpackage

/* tb/sdr_port_checker.sv */
// Concurrent checks on the serial port pins and bus
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defines.svh"
module sdr_port_checker
  import sdr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire sdr_pkg::sdr_addr_t addr_i,
  input wire sdr_pkg::sdr_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic sck_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o,
  input wire logic ss_n_i,
  input wire logic ss_pin_free_o
);
  logic csr_wr, ctl_wr, ssm_wr, on_wr;
  // Decoded register writes
  assign csr_wr = wr_i && addr_i == `SDR_ADDR_CSR;
  assign ctl_wr = wr_i && addr_i == `SDR_ADDR_CTRL;
  assign ssm_wr = csr_wr && wdata_i[1];
  assign on_wr = ctl_wr && wdata_i[6] && wdata_i[4];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Master enabled while the select pin is held low
  sequence s_fault;
    (sck_oe_o && !ss_pin_free_o && !ss_n_i) [*2];
  endsequence
  a_pins_excl: assert property (!(mosi_oe_o && miso_oe_o))
    else $error("both data pins driven");
  a_mosi_master: assert property (mosi_oe_o |-> sck_oe_o)
    else $error("data out without master");
  a_fault_drop: assert property (s_fault |-> ##[0:6] !sck_oe_o)
    else $error("fault left master on");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
  a_free_cause: assert property ($rose(ss_pin_free_o) |-> $past(ssm_wr) || $past(ssm_wr, 2))
    else $error("pin freed without write");
  a_sck_cause: assert property ($rose(sck_oe_o) |-> $past(on_wr) || $past(on_wr, 2))
    else $error("clock driven without write");
  a_sod_off: assert property (csr_wr && wdata_i[2] |-> ##[1:3] !(mosi_oe_o || miso_oe_o))
    else $error("output still driven");
  a_irq_gate: assert property (ctl_wr && !wdata_i[7] |-> ##[1:3] !irq_o)
    else $error("irq despite disable");
endmodule
bind sdr_port sdr_port_checker u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
  .ss_n_i(ss_n_i), .ss_pin_free_o(ss_pin_free_o));
`default_nettype wire

/* tb/sdr_slave_model.sv */
// Serial slave on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module sdr_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh;
  initial
  begin
    miso_o = 1'b0;
    rx_o = 8'h00;
  end
  // Load answer on select; released line shows inverse
  always @(negedge sel_n_i) {sh, miso_o} = {tx_i, tx_i[7]};
  always @(posedge sel_n_i) miso_o = ~miso_o;
  // Capture on leading edge, next bit on trailing edge
  always @(posedge sck_i) if (!sel_n_i) {rx_o, sh} = {rx_o[6:0], mosi_i, sh[6:0], 1'b0};
  always @(negedge sck_i) if (!sel_n_i) miso_o = sh[7];
endmodule
`default_nettype wire

/* tb/tb_sdr_port.sv */
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defines.svh"
module tb_sdr_port;
  import sdr_pkg::*;
  localparam sdr_addr_t DA = `SDR_ADDR_DATA;
  localparam sdr_addr_t CT = `SDR_ADDR_CTRL;
  localparam sdr_addr_t CS = `SDR_ADDR_CSR;
  logic clk, rst_n, wr_s, rd_s, tb_sck, tb_mosi, ss_n, sel_n;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, free, m_miso;
  logic [7:0] rdata;
  logic [31:0] rnd;
  sdr_addr_t addr;
  sdr_byte_t wdata, m_tx, m_rx, tx;
  int err_total, cmp_count, seed;
  wire sck_w = sck_oe ? sck_o : tb_sck;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : m_miso;
  sdr_port dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
    .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe), .ss_n_i(ss_n), .ss_pin_free_o(free));
  sdr_slave_model u_mdl (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(sel_n), .tx_i(m_tx),
    .miso_o(m_miso), .rx_o(m_rx));
  // Core clock, 20 ns
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Expected status byte: four flags, reserved zero, low control bits
  function automatic sdr_byte_t csr_of(input logic done, input logic write_collision_flag, input logic overrun_flag,
    input logic master_fault_flag, input logic [2:0] low);
    return {done, write_collision_flag, overrun_flag, master_fault_flag, 1'b0, low};
  endfunction
  task automatic wr(input sdr_addr_t a, input sdr_byte_t d);
    @(posedge clk);
    {addr, wdata, wr_s} <= {a, d, 1'b1};
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input sdr_addr_t a, input sdr_byte_t exp);
    @(posedge clk);
    {addr, rd_s} <= {a, 1'b1};
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic pin(ref logic s, input logic exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({7'h00, s}, {7'h00, exp});
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 400 && irq !== 1'b1; k++)
      @(posedge clk);
    if (irq !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t no interrupt", $time);
      conclude();
    end
  endtask
  task automatic xfer(input sdr_byte_t d, input logic twice);
    @(posedge clk);
    sel_n <= 1'b0;
    wr(DA, d);
    if (twice)
      wr(DA, ~d);
    wait_irq();
    sel_n <= 1'b1;
  endtask
  // Far-side master: 160 ns clock, data moves on the falling edge
  task automatic send(input sdr_byte_t b, input sdr_byte_t e);
    @(posedge clk);
    chk({7'h00, miso_oe}, 8'h01);
    for (int k = 7; k >= 0; k--)
    begin
      tb_mosi <= b[k];
      repeat (5) @(posedge clk);
      chk({7'h00, miso_w}, {7'h00, e[k]});
      tb_sck <= 1'b1;
      repeat (3) @(posedge clk);
      tb_sck <= 1'b0;
    end
    tb_mosi <= ~b[0];
  endtask
  // Main sequence
  initial
  begin
    {seed, err_total, cmp_count} = {32'd37942, 32'd0, 32'd0};
    {rst_n, wr_s, rd_s, tb_sck, tb_mosi, ss_n, sel_n} = 7'b0000011;
    {addr, wdata, m_tx} = 24'h00_0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(CT, 8'h00);
    rd(CS, 8'h00);
    rd(8'h24, 8'h00);
    wr(CS, 8'hFF);
    rd(CS, 8'h07);
    wr(CS, 8'h00);
    wr(CT, 8'hD0);
    for (int i = 0; i < 5; i++)
    begin
      rnd = $random(seed);
      tx = (i == 0) ? 8'h80 : rnd[15:8];
      m_tx <= rnd[7:0];
      xfer(tx, 1'b0);
      rd(CS, 8'h80);
      chk({7'h00, irq}, 8'h01);
      rd(DA, m_tx);
      chk(m_rx, tx);
      rd(CS, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    xfer(8'h5A, 1'b0);
    wr(DA, 8'hC3);
    rd(CS, 8'h80);
    rd(DA, m_tx);
    chk(m_rx, 8'h5A);
    xfer(8'h0F, 1'b1);
    rd(CS, csr_of(1'b1, 1'b1, 1'b0, 1'b0, 3'h0));
    chk(m_rx, 8'h0F);
    rd(DA, m_tx);
    rd(CS, 8'h00);
    @(posedge clk);
    ss_n <= 1'b0;
    wait_irq();
    rd(CS, 8'h10);
    rd(CT, 8'h80);
    @(posedge clk);
    ss_n <= 1'b1;
    wr(CT, 8'h80);
    rd(CS, 8'h00);
    wr(CT, 8'hC0);
    rnd = $random(seed);
    wr(DA, rnd[15:8]);
    wr(CS, 8'h02);
    pin(free, 1'b1);
    send(rnd[7:0], rnd[15:8]);
    wait_irq();
    send(~rnd[7:0], rnd[7:0]);
    repeat (6) @(posedge clk);
    wr(CT, 8'h40);
    pin(irq, 1'b0);
    wr(CT, 8'hC0);
    rd(CS, csr_of(1'b1, 1'b0, 1'b1, 1'b0, 3'h2));
    rd(DA, rnd[7:0]);
    rd(CS, 8'h02);
    wr(CS, 8'h03);
    pin(miso_oe, 1'b0);
    wr(CS, 8'h06);
    pin(miso_oe, 1'b0);
    wr(CS, 8'h02);
    pin(miso_oe, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
